// ### rtl/link_status_pkg.sv
// Package with register layout, field positions, codes and timing for the link status block.
package link_status_pkg;

  // Register index 0x052 counts 32-bit words, so the byte address is four times the index.
  localparam logic [11:0] LINK_STATUS_INDEX = 12'h052;
  localparam logic [11:0] LINK_STATUS_ADDR  = 12'(LINK_STATUS_INDEX * 4);
  localparam logic [11:0] LINK_CONTROL_ADDR = 12'h150;

  localparam int SPEED_LSB     = 0;
  localparam int WIDTH_LSB     = 4;
  localparam int TRAINING_ERROR_BIT      = 10;
  localparam int TRAIN_BIT     = 11;
  localparam int CCLK_BIT      = 12;
  localparam int DLLA_BIT      = 13;
  localparam int BWM_BIT       = 14;
  localparam int ABW_BIT       = 15;
  localparam int RETRAIN_BIT   = 5;
  localparam int BWM_IEN_BIT   = 10;
  localparam int ABW_IEN_BIT   = 11;

  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [3:0] SPEED_GEN2 = 4'h2;
  localparam logic [5:0] WIDTH_NONE = 6'h00;

  localparam int RETRAIN_DELAY_NS = 1000000;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int RETRAIN_DELAY_CYC = RETRAIN_DELAY_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       in_config_recovery;
    logic       trained;
    logic       dl_active;
    logic       dl_down;
    logic [3:0] speed;
    logic [5:0] width;
    logic       retrain_done;
    logic       auto_reliability;
    logic       auto_other;
    logic       ds_change;
    logic       ds_change_auto;
  } phy_status_t;

  typedef struct packed {
    logic       upstream_port;
    logic [5:0] configured_max_width;
    logic       max_width_supported;
    logic       link_active_capable;
    logic       bandwidth_notify_capable;
  } port_config_t;

endpackage : link_status_pkg

// ### rtl/link_status_register.sv
// Link status register of one switch port with an APB slave for the status and control words.
//
// Summary of operation
// - Current speed in bits 3:0, 1 means 2.5G, 2 means 5G, reset 1.
// - Negotiated width in bits 9:4 with one-hot-like width codes.
// - Unsupported configured maximum width is reported in place of negotiated width.
// - Supported maximum but untrained link reports width zero.
// - Training error bit is read-only and always zero.
// - Training bit set while LTSSM is in Configuration or Recovery.
// - Training bit set at once when software writes retrain one.
// - Upstream port retrain write acts only after one millisecond.
// - Training bit clears when LTSSM leaves Configuration or Recovery.
// - Common clock bit loads upstream or downstream strap after reset.
// - EEPROM loader may overwrite the common clock bit.
// - Data link active bit mirrors data link state, reset zero.
// - Data link active bit held zero without link active capability.
// - Bandwidth flag set on completed software retrain without DL_Down.
// - Bandwidth flag set on autonomous reliability change without DL_Down.
// - Bandwidth flag set on non-autonomous downstream-started change.
// - Autonomous flag set on autonomous change for other reasons.
// - Autonomous flag set on autonomous downstream-started change.
// - Both flags reset zero, sticky, cleared by writing one.
// - Both flags held zero without bandwidth notification capability.
// - Both flags hardwired zero on the upstream port.
// - Bandwidth flag raises interrupt when its enable is set.
// - Autonomous flag raises interrupt when its enable is set.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module link_status_register #(
  parameter int RETRAIN_DELAY = link_status_pkg::RETRAIN_DELAY_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire link_status_pkg::phy_status_t phy,
  input  wire link_status_pkg::port_config_t cfg,
  input  wire logic                         upstream_common_clock_strap,
  input  wire logic                         downstream_common_clock_strap,
  input  wire logic                         eeprom_cclk_load,
  input  wire logic                         eeprom_cclk_value,
  output logic                              retrain_request,
  output logic                              bandwidth_irq
);

  initial begin
    if (RETRAIN_DELAY < 1 || RETRAIN_DELAY > 16777215) $error("RETRAIN_DELAY out of range");
  end

  typedef enum logic [2:0] {
    RT_IDLE = 3'b001,
    RT_WAIT = 3'b010,
    RT_GO   = 3'b100
  } retrain_state_t;

  retrain_state_t retrain_state_reg;
  retrain_state_t retrain_state_next;
  logic [23:0]    delay_reg;
  logic [23:0]    delay_next;
  logic           pending_reg;
  logic           sw_retrain_reg;
  logic           strap_loaded_reg;
  logic           cclk_reg;
  logic           bwm_reg;
  logic           abw_reg;
  logic           bwm_ien_reg;
  logic           abw_ien_reg;
  logic           dl_down_seen_reg;
  logic [3:0]     speed_reg;
  logic [5:0]     width_reg;
  logic           train_reg;
  logic           dlla_reg;
  logic [31:0]    prdata_reg;

  wire access      = psel && penable;
  wire hit_status  = paddr == link_status_pkg::LINK_STATUS_ADDR;
  wire hit_control = paddr == link_status_pkg::LINK_CONTROL_ADDR;
  wire wr_status   = access && pwrite && hit_status && pstrb[1];
  wire wr_control  = access && pwrite && hit_control;
  wire retrain_wr  = wr_control && pstrb[0] && pwdata[link_status_pkg::RETRAIN_BIT];
  wire flags_live  = cfg.bandwidth_notify_capable && !cfg.upstream_port;
  wire clear_bwm   = wr_status && pwdata[link_status_pkg::BWM_BIT];
  wire clear_abw   = wr_status && pwdata[link_status_pkg::ABW_BIT];
  wire set_bwm     = !phy.dl_down && !dl_down_seen_reg &&
                     ((phy.retrain_done && sw_retrain_reg) || phy.auto_reliability)
                     || (phy.ds_change && !phy.ds_change_auto);
  wire set_abw     = phy.auto_other || (phy.ds_change && phy.ds_change_auto);

  assign pready  = 1'b1;
  assign pslverr = access && !hit_status && !hit_control;
  assign prdata  = prdata_reg;

  // The width field follows the configured maximum when the port cannot serve it.
  wire [5:0] width_now = !cfg.max_width_supported ? cfg.configured_max_width :
                         (phy.trained ? phy.width : link_status_pkg::WIDTH_NONE);

  wire [15:0] status_word = {abw_reg, bwm_reg, dlla_reg, cclk_reg, train_reg,
                             1'b0, width_reg, speed_reg};

  always_comb begin
    retrain_state_next = retrain_state_reg;
    delay_next         = delay_reg;
    case (retrain_state_reg)
      RT_IDLE: begin
        if (retrain_wr && cfg.upstream_port) begin
          retrain_state_next = RT_WAIT;
          delay_next         = 24'(RETRAIN_DELAY - 1);
        end else if (retrain_wr) begin
          retrain_state_next = RT_GO;
        end
      end
      RT_WAIT: begin
        if (delay_reg == 24'h000000) begin
          retrain_state_next = RT_GO;
        end else begin
          delay_next = delay_reg - 24'h000001;
        end
      end
      RT_GO:   retrain_state_next = RT_IDLE;
      default: retrain_state_next = RT_IDLE;
    endcase
  end

  assign retrain_request = retrain_state_reg == RT_GO;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      retrain_state_reg <= RT_IDLE;
      delay_reg         <= 24'h000000;
    end else begin
      retrain_state_reg <= retrain_state_next;
      delay_reg         <= delay_next;
    end
  end

  // Pending covers the gap between the retrain write and the LTSSM entering training.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending_reg    <= 1'b0;
      sw_retrain_reg <= 1'b0;
      train_reg      <= 1'b0;
    end else begin
      if (retrain_wr) begin
        pending_reg <= 1'b1;
      end else if (phy.in_config_recovery) begin
        pending_reg <= 1'b0;
      end
      if (retrain_wr) begin
        sw_retrain_reg <= 1'b1;
      end else if (phy.retrain_done || phy.dl_down) begin
        sw_retrain_reg <= 1'b0;
      end
      train_reg <= phy.in_config_recovery || retrain_wr ||
                   (pending_reg && !phy.in_config_recovery);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      speed_reg        <= link_status_pkg::SPEED_GEN1;
      width_reg        <= link_status_pkg::WIDTH_NONE;
      dlla_reg         <= 1'b0;
      dl_down_seen_reg <= 1'b0;
    end else begin
      speed_reg        <= phy.speed;
      width_reg        <= width_now;
      dlla_reg         <= phy.dl_active && cfg.link_active_capable;
      dl_down_seen_reg <= phy.dl_down;
    end
  end

  // Straps are caught by the clock after reset release, never inside the reset term.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_loaded_reg <= 1'b0;
      cclk_reg         <= 1'b0;
    end else if (!strap_loaded_reg) begin
      strap_loaded_reg <= 1'b1;
      cclk_reg         <= cfg.upstream_port ? upstream_common_clock_strap
                                            : downstream_common_clock_strap;
    end else if (eeprom_cclk_load) begin
      cclk_reg <= eeprom_cclk_value;
    end
  end

  // A set arriving with a clear wins so that no event is lost.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bwm_reg <= 1'b0;
      abw_reg <= 1'b0;
    end else begin
      bwm_reg <= flags_live && (set_bwm || (bwm_reg && !clear_bwm));
      abw_reg <= flags_live && (set_abw || (abw_reg && !clear_abw));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bwm_ien_reg <= 1'b0;
      abw_ien_reg <= 1'b0;
    end else if (wr_control && pstrb[1]) begin
      bwm_ien_reg <= flags_live && pwdata[link_status_pkg::BWM_IEN_BIT];
      abw_ien_reg <= flags_live && pwdata[link_status_pkg::ABW_IEN_BIT];
    end
  end

  assign bandwidth_irq = (bwm_reg && bwm_ien_reg) || (abw_reg && abw_ien_reg);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_status) begin
        prdata_reg <= {16'h0000, status_word};
      end else if (hit_control) begin
        prdata_reg <= {20'h00000, abw_ien_reg, bwm_ien_reg, 10'h000};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // The checks below, apart from the three interrupt checks, watch registered state one edge after the inputs that drive it.
  // They are disabled during reset, so the first edge after release compares settled values only.

  a_train_on_retrain: assert property (@(posedge sys_clk) disable iff (reset)
    retrain_wr
    |=> train_reg)
    else $error("training bit not set after retrain write");

  a_train_follows_ltssm: assert property (@(posedge sys_clk) disable iff (reset)
    phy.in_config_recovery
    |=> train_reg)
    else $error("training bit missing in training");

  a_train_clears: assert property (@(posedge sys_clk) disable iff (reset)
    !phy.in_config_recovery && !pending_reg && !retrain_wr
    |=> !train_reg)
    else $error("training bit stuck");

  a_flags_upstream: assert property (@(posedge sys_clk) disable iff (reset)
    $past(cfg.upstream_port)
    |-> !bwm_reg && !abw_reg)
    else $error("flags set on upstream port");

  a_flags_no_cap: assert property (@(posedge sys_clk) disable iff (reset)
    $past(!cfg.bandwidth_notify_capable)
    |-> !bwm_reg && !abw_reg)
    else $error("flags without capability");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    bwm_reg && !clear_bwm && flags_live
    |=> bwm_reg)
    else $error("bandwidth flag lost");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
    abw_reg && clear_abw && !set_abw
    |=> !abw_reg)
    else $error("autonomous flag not cleared");

  a_abw_set: assert property (@(posedge sys_clk) disable iff (reset)
    phy.auto_other && flags_live
    |=> abw_reg)
    else $error("autonomous flag not set");

  a_dlla_cap: assert property (@(posedge sys_clk) disable iff (reset)
    $past(!cfg.link_active_capable)
    |-> !dlla_reg)
    else $error("link active without capability");

  a_width_unsup: assert property (@(posedge sys_clk) disable iff (reset)
    !cfg.max_width_supported
    |=> width_reg == $past(cfg.configured_max_width))
    else $error("width not configured maximum");

  sequence upstream_retrain_s;
    retrain_wr && cfg.upstream_port;
  endsequence

  a_retrain_delay: assert property (@(posedge sys_clk) disable iff (reset)
    upstream_retrain_s
    |=> !retrain_request)
    else $error("upstream retrain not delayed");

  a_irq_bwm: assert property (@(posedge sys_clk) disable iff (reset)
    bwm_reg && bwm_ien_reg
    |-> bandwidth_irq)
    else $error("missing bandwidth interrupt");

  a_irq_abw: assert property (@(posedge sys_clk) disable iff (reset)
    abw_reg && abw_ien_reg
    |-> bandwidth_irq)
    else $error("missing autonomous interrupt");

  a_irq_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    !bwm_reg && !abw_reg
    |-> !bandwidth_irq)
    else $error("interrupt without a flag");

  // A retrain only counts when the data link stayed up now and one cycle ago.
  sequence quiet_link_s;
    !phy.dl_down && !dl_down_seen_reg;
  endsequence

  a_bwm_retrain: assert property (@(posedge sys_clk) disable iff (reset)
    quiet_link_s ##0 (phy.retrain_done && sw_retrain_reg && flags_live)
    |=> bwm_reg)
    else $error("bandwidth flag missed after retrain");

  a_bwm_reliab: assert property (@(posedge sys_clk) disable iff (reset)
    quiet_link_s ##0 (phy.auto_reliability && flags_live)
    |=> bwm_reg)
    else $error("bandwidth flag missed after reliability change");

  a_bwm_dl_down: assert property (@(posedge sys_clk) disable iff (reset)
    phy.dl_down && !bwm_reg && !(phy.ds_change && !phy.ds_change_auto)
    |=> !bwm_reg)
    else $error("bandwidth flag set across link down");

  a_bwm_ds: assert property (@(posedge sys_clk) disable iff (reset)
    phy.ds_change && !phy.ds_change_auto && flags_live
    |=> bwm_reg)
    else $error("bandwidth flag missed on partner change");

  a_abw_ds: assert property (@(posedge sys_clk) disable iff (reset)
    phy.ds_change && phy.ds_change_auto && flags_live
    |=> abw_reg)
    else $error("autonomous flag missed on partner change");

  a_dlla_mirror: assert property (@(posedge sys_clk) disable iff (reset)
    cfg.link_active_capable
    |=> dlla_reg == $past(phy.dl_active))
    else $error("link active bit does not follow link");

  a_speed_follow: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1
    |=> speed_reg == $past(phy.speed))
    else $error("speed field does not follow link");

  a_width_untrained: assert property (@(posedge sys_clk) disable iff (reset)
    cfg.max_width_supported && !phy.trained
    |=> width_reg == link_status_pkg::WIDTH_NONE)
    else $error("width not zero on untrained link");

  // Only the loader may move the clock bit once the strap is in, so bus writes leave it alone.
  a_cclk_hold: assert property (@(posedge sys_clk) disable iff (reset)
    strap_loaded_reg && !eeprom_cclk_load
    |=> $stable(cclk_reg))
    else $error("common clock bit changed without loader");

  a_retrain_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    retrain_request
    |=> !retrain_request)
    else $error("retrain request longer than one cycle");

  a_ds_retrain: assert property (@(posedge sys_clk) disable iff (reset)
    retrain_wr && !cfg.upstream_port && retrain_state_reg == RT_IDLE
    |=> retrain_request)
    else $error("downstream retrain not issued");

endmodule : link_status_register

// ### sim/link_partner_model.sv
// Behavioural link partner and LTSSM view that feeds the port's physical-layer status.
`timescale 1ns/1ps
module link_partner_model #(
  parameter int TRAIN_CYCLES = 12
) (
  input  wire logic                    sys_clk,
  input  wire logic                    retrain_request,
  output link_status_pkg::phy_status_t phy
);
  int left = 0;
  initial phy = '0;
  // Recovery is held long enough that software can see training in progress.
  always @(posedge sys_clk) begin
    phy.retrain_done <= 1'b0;
    if (retrain_request === 1'b1) begin
      left <= TRAIN_CYCLES;
      phy.in_config_recovery <= 1'b1;
    end else if (left == 1) begin
      left <= 0;
      phy.in_config_recovery <= 1'b0;
      phy.retrain_done <= 1'b1;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
  task automatic set_link(input logic [3:0] s, input logic [5:0] w, input logic t, input logic a, input logic d);
    phy.speed <= s;
    phy.width <= w;
    phy.trained <= t;
    phy.dl_active <= a;
    phy.dl_down <= d;
  endtask : set_link
  task automatic pulse(input logic [3:0] p);
    phy[3:0] <= p;
    @(posedge sys_clk);
    phy[3:0] <= 4'h0;
  endtask : pulse
endmodule : link_partner_model

// ### sim/link_status_register_tb.sv
// Self-checking bench for the link status register with a behavioural link partner.
`timescale 1ns/1ps
module link_status_register_tb;
  localparam int                 DLY  = 5;
  localparam logic [11:0]        STAT = link_status_pkg::LINK_STATUS_ADDR;
  localparam logic [11:0]        CTRL = link_status_pkg::LINK_CONTROL_ADDR;
  logic                          sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic                          retrain_request, bandwidth_irq, us_strap, ds_strap, ee_load, ee_val;
  logic [11:0]                   paddr;
  logic [31:0]                   pwdata, prdata, rd;
  logic [3:0]                    pstrb;
  link_status_pkg::phy_status_t  phy;
  link_status_pkg::port_config_t cfg;
  int                            mismatches = 0, check_count = 0, cyc = 0, wr_cyc = 0, rq_cyc = 0;

  link_status_register #(.RETRAIN_DELAY(DLY)) i_link_status_register (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phy(phy), .cfg(cfg),
    .upstream_common_clock_strap(us_strap), .downstream_common_clock_strap(ds_strap), .eeprom_cclk_load(ee_load),
    .eeprom_cclk_value(ee_val), .retrain_request(retrain_request), .bandwidth_irq(bandwidth_irq));
  link_partner_model i_link_partner_model (.sys_clk(sys_clk), .retrain_request(retrain_request), .phy(phy));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (retrain_request === 1'b1) rq_cyc <= cyc;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    wr_cyc = cyc + 1;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  // Status fields lag the physical inputs by a cycle, so a read first lets one edge pass.
  task automatic rs;
    @(posedge sys_clk);
    apb(1'b0, STAT, 32'h0);
  endtask : rs
  task automatic wait_guard(input int n);
    if (n >= 100) begin
      mismatches++;
      final_report();
    end
  endtask : wait_guard
  task automatic do_reset(input logic up);
    cfg.upstream_port <= up;
    reset <= 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rs();
    check({31'h0, rd[12]}, {31'h0, up ? us_strap : ds_strap}, "clock bit from strap");
  endtask : do_reset
  task automatic t_reset_values;
    apb(1'b1, STAT, 32'hFFFF);
    rs();
    check({16'h0, rd[15:0]}, 32'h1001, "status after reset and write");
    apb(1'b0, 12'h400, 32'h0);
    check({31'h0, err}, 32'h1, "error on unmapped read");
    ee_val <= 1'b0;
    ee_load <= 1'b1;
    @(posedge sys_clk);
    ee_load <= 1'b0;
    rs();
    check({16'h0, rd[15:0]}, 32'h0001, "clock bit after loader");
  endtask : t_reset_values
  task automatic t_fields;
    logic [5:0] codes [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h20};
    foreach (codes[i]) begin
      i_link_partner_model.set_link(4'h2, codes[i], 1'b1, 1'b1, 1'b0);
      rs();
      check({16'h0, rd[15:0]}, {16'h0, 6'h08, codes[i], 4'h2}, "speed, width, link active");
    end
    cfg.link_active_capable <= 1'b0;
    cfg.max_width_supported <= 1'b0;
    cfg.configured_max_width <= 6'h0C;
    i_link_partner_model.set_link(4'h1, 6'h01, 1'b1, 1'b1, 1'b0);
    rs();
    check({16'h0, rd[15:0]}, 32'h00C1, "width from unsupported maximum");
    cfg.link_active_capable <= 1'b1;
    cfg.max_width_supported <= 1'b1;
  endtask : t_fields
  task automatic t_flags;
    logic [3:0] ev [4]  = '{4'b1000, 4'b0100, 4'b0010, 4'b0011};
    logic [1:0] flg [4] = '{2'b01, 2'b10, 2'b01, 2'b10};
    apb(1'b1, CTRL, 32'h0C00);
    foreach (ev[i]) begin
      i_link_partner_model.pulse(ev[i]);
      apb(1'b1, STAT, 32'h0);
      rs();
      check({30'h0, rd[15:14]}, {30'h0, flg[i]}, "flag set, kept by zero");
      check({31'h0, bandwidth_irq}, 32'h1, "interrupt from flag");
      apb(1'b1, STAT, {16'h0, flg[i], 14'h0});
      rs();
      check({30'h0, rd[15:14]}, 32'h0, "flag cleared by one");
    end
    i_link_partner_model.set_link(4'h1, 6'h01, 1'b1, 1'b1, 1'b1);
    i_link_partner_model.pulse(4'b1000);
    rs();
    check({30'h0, rd[15:14]}, 32'h0, "no flag across link down");
    i_link_partner_model.set_link(4'h1, 6'h01, 1'b1, 1'b1, 1'b0);
    cfg.bandwidth_notify_capable <= 1'b0;
    i_link_partner_model.pulse(4'b0100);
    rs();
    check({30'h0, rd[15:14]}, 32'h0, "no flag without capability");
    cfg.bandwidth_notify_capable <= 1'b1;
  endtask : t_flags
  task automatic t_retrain(input logic up);
    int n, t;
    rq_cyc = 0;
    apb(1'b1, CTRL, 32'h0020);
    t = wr_cyc;
    apb(1'b0, STAT, 32'h0);
    check({31'h0, rd[11]}, 32'h1, "training flagged at once");
    for (n = 0; rq_cyc == 0 && n < 100; n++) @(posedge sys_clk);
    wait_guard(n);
    check(32'(rq_cyc - t), up ? 32'(DLY) : 32'h0, "retrain request delay");
    rs();
    check({31'h0, rd[11]}, 32'h1, "training during recovery");
    for (n = 0; phy.in_config_recovery !== 1'b0 && n < 100; n++) @(posedge sys_clk);
    wait_guard(n);
    rs();
    check({30'h0, rd[14], rd[11]}, {30'h0, ~up, 1'b0}, "training over, retrain flag");
  endtask : t_retrain

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    us_strap = 1'b0;
    ds_strap = 1'b1;
    ee_load = 1'b0;
    ee_val = 1'b1;
    cfg = '{1'b0, 6'h10, 1'b1, 1'b1, 1'b1};
    i_link_partner_model.set_link(4'h1, 6'h01, 1'b0, 1'b0, 1'b0);
    do_reset(1'b0);
    t_reset_values();
    t_fields();
    t_flags();
    t_retrain(1'b0);
    do_reset(1'b1);
    t_retrain(1'b1);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
endmodule : link_status_register_tb
